/* File: logic/rgbcd_consts.svh */
`ifndef RGBCD_CONSTS_SVH
`define RGBCD_CONSTS_SVH

// bus frame
`define RGBCD_ADDR_BYTE     8'h70
`define RGBCD_SEL_HI        7
`define RGBCD_SEL_LO        5
`define RGBCD_VAL_HI        4
`define RGBCD_VAL_LO        0
`define RGBCD_BIT_LAST      3'h7

// timing, clock 200 MHz
`define RGBCD_CLK_NS        5
`define RGBCD_FADE_UNIT_NS  8000000
`define RGBCD_FADE_UNIT_CYC (`RGBCD_FADE_UNIT_NS / `RGBCD_CLK_NS)
`define RGBCD_PWM_SLOT_NS   15360
`define RGBCD_PWM_SLOT_CYC  (`RGBCD_PWM_SLOT_NS / `RGBCD_CLK_NS)
`define RGBCD_QTR_NS        625
`define RGBCD_QTR_CYC       (`RGBCD_QTR_NS / `RGBCD_CLK_NS)

// step and duty limits
`define RGBCD_STEP_TOP      5'h1F
`define RGBCD_STEP_SAT      5'h1E
`define RGBCD_DUTY_FULL     5'h1F
`define RGBCD_PWM_LAST      5'h1E
`define RGBCD_CUR_FULL      16'h7FFE

// controller registers
`define RGBCD_REG_CMD       4'h0
`define RGBCD_REG_STAT      4'h4
`define RGBCD_STAT_BUSY     0
`define RGBCD_STAT_NACK     1

`endif

/* File: logic/rgbcd_dev.sv */
// Contract
// - answer only address byte 0x70
// - receive only, read frames unanswered
// - frame is address byte, one command
// - top three bits select function
// - select 000 forces all currents zero
// - select 001 stores shared current step
// - selects 010-100 load red/green/blue duty
// - selects 101/110 store up/down targets
// - select 111 sets step time, runs
// - current proportional 1/(31-n), 0 off
// - duration is step time times steps
// - master sends target before run command
// - each modulator has 32 duty steps
// - dimming works upward and downward
// - duty 0 off, duty 0x1F on
// - step count is absolute index difference
// - change starts at data byte acknowledge
// - direct current step applies immediately
//
// Design decisions made here: the plain strobed port and the register addresses.
`include "rgbcd_consts.svh"
module rgbcd_dev #(
  parameter int FADE_UNIT_CYC = `RGBCD_FADE_UNIT_CYC,
  parameter int PWM_SLOT_CYC  = `RGBCD_PWM_SLOT_CYC
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // link
  rgbcd_if.dev            link,
  // led drive
  output logic            red_modulator,
  output logic            green_modulator,
  output logic            blue_modulator,
  output logic [15:0]     led_output_current,
  output logic [4:0]      current_step,
  output logic [4:0]      fade_steps_left,
  output logic            fade_busy
);

  function automatic logic [4:0] step_dist(input logic [4:0] a, input logic [4:0] b);
    step_dist = (a > b) ? 5'(a - b) : 5'(b - a);
  endfunction

  function automatic logic [15:0] step_current(input logic [4:0] n);
    logic [4:0] m;
    m = (n == `RGBCD_STEP_TOP) ? `RGBCD_STEP_SAT : n;
    if (n == 5'h00) begin
      step_current = 16'h0000;
    end else begin
      step_current = 16'(`RGBCD_CUR_FULL / (`RGBCD_STEP_TOP - m));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling

  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic       scl_f;
  logic       sda_f;
  logic       scl_prev;
  logic       sda_prev;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], link.scl};
      sda_sync <= {sda_sync[1:0], link.sda};
    end
  end

  // a level counts once stages two and three agree
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      if (scl_sync[1] == scl_sync[2]) begin
        scl_f <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
      scl_prev <= scl_f;
      sda_prev <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise   = scl_f & ~scl_prev;
  assign scl_fall   = ~scl_f & scl_prev;
  assign start_seen = scl_f & scl_prev & sda_prev & ~sda_f;
  assign stop_seen  = scl_f & scl_prev & ~sda_prev & sda_f;

  ////////////////////////////////////////////////////////////////////////////
  // frame receiver

  rgbcd_pkg::rgbcd_dstate_t st;
  logic [7:0] shreg;
  logic [2:0] bitn;
  logic       ack_drive;
  logic       cmd_stb;
  logic [7:0] cmd_byte;
  logic       got8;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st        <= rgbcd_pkg::RGBCD_D_IDLE;
      shreg     <= 8'h00;
      bitn      <= 3'h0;
      ack_drive <= 1'b0;
    end else if (start_seen) begin
      st        <= rgbcd_pkg::RGBCD_D_ADDR;
      bitn      <= 3'h0;
      ack_drive <= 1'b0;
    end else if (stop_seen) begin
      st        <= rgbcd_pkg::RGBCD_D_IDLE;
      ack_drive <= 1'b0;
    end else begin
      case (st)
        rgbcd_pkg::RGBCD_D_ADDR, rgbcd_pkg::RGBCD_D_DATA: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_f};
            bitn  <= 3'(bitn + 3'h1);
          end
          if (scl_fall && got8) begin
            // full byte in; a zero byte is legal, so shreg cannot mark it
            if (st == rgbcd_pkg::RGBCD_D_DATA) begin
              st        <= rgbcd_pkg::RGBCD_D_ACKD;
              ack_drive <= 1'b1;
            end else if (shreg == `RGBCD_ADDR_BYTE) begin
              st        <= rgbcd_pkg::RGBCD_D_ACKA;
              ack_drive <= 1'b1;
            end else begin
              st <= rgbcd_pkg::RGBCD_D_SKIP;
            end
          end
        end
        rgbcd_pkg::RGBCD_D_ACKA: begin
          if (scl_fall) begin
            st        <= rgbcd_pkg::RGBCD_D_DATA;
            ack_drive <= 1'b0;
            shreg     <= 8'h00;
          end
        end
        rgbcd_pkg::RGBCD_D_ACKD: begin
          if (scl_fall) begin
            // further bytes in this frame are not taken
            st        <= rgbcd_pkg::RGBCD_D_SKIP;
            ack_drive <= 1'b0;
          end
        end
        default: begin
          ack_drive <= 1'b0;
        end
      endcase
    end
  end

  // level from the eighth rise to the next fall; cleared by start and stop so
  // a stale byte from an earlier frame never looks complete
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      got8 <= 1'b0;
    end else if (start_seen || stop_seen || scl_fall) begin
      got8 <= 1'b0;
    end else if (scl_rise && bitn == `RGBCD_BIT_LAST &&
                 (st == rgbcd_pkg::RGBCD_D_ADDR || st == rgbcd_pkg::RGBCD_D_DATA)) begin
      got8 <= 1'b1;
    end
  end

  // command acts on the acknowledge clock of the data byte
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_stb  <= 1'b0;
      cmd_byte <= 8'h00;
    end else begin
      cmd_stb <= (st == rgbcd_pkg::RGBCD_D_ACKD) && scl_rise;
      if ((st == rgbcd_pkg::RGBCD_D_DATA) && got8) begin
        cmd_byte <= shreg;
      end
    end
  end

  assign link.sda_dev_o  = 1'b0;
  assign link.sda_dev_oe = ack_drive;

  ////////////////////////////////////////////////////////////////////////////
  // command registers

  rgbcd_pkg::rgbcd_func_t sel;
  logic [4:0] val;
  logic [4:0] red_duty_level;
  logic [4:0] green_duty_level;
  logic [4:0] blue_duty_level;
  logic [4:0] rise_target_step;
  logic [4:0] fall_target_step;
  logic [4:0] fade_step_time_run;
  logic [4:0] fade_target;

  assign sel = rgbcd_pkg::rgbcd_func_t'(cmd_byte[`RGBCD_SEL_HI:`RGBCD_SEL_LO]);
  assign val = cmd_byte[`RGBCD_VAL_HI:`RGBCD_VAL_LO];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      red_duty_level     <= 5'h00;
      green_duty_level   <= 5'h00;
      blue_duty_level    <= 5'h00;
      rise_target_step   <= 5'h00;
      fall_target_step   <= 5'h00;
      fade_step_time_run <= 5'h00;
      fade_target        <= 5'h00;
    end else if (cmd_stb) begin
      case (sel)
        rgbcd_pkg::RGBCD_F_RED:   red_duty_level   <= val;
        rgbcd_pkg::RGBCD_F_GREEN: green_duty_level <= val;
        rgbcd_pkg::RGBCD_F_BLUE:  blue_duty_level  <= val;
        rgbcd_pkg::RGBCD_F_UP: begin
          rise_target_step <= val;
          fade_target      <= val;
        end
        rgbcd_pkg::RGBCD_F_DOWN: begin
          fall_target_step <= val;
          fade_target      <= val;
        end
        rgbcd_pkg::RGBCD_F_RUN: fade_step_time_run <= val;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current step and gradual dimming

  logic [$clog2(FADE_UNIT_CYC)-1:0] unit_cnt;
  logic [4:0]                       unit_left;
  logic                             unit_tick;

  assign unit_tick = fade_busy && (unit_cnt == ($clog2(FADE_UNIT_CYC))'(FADE_UNIT_CYC - 1));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      current_step    <= 5'h00;
      fade_busy       <= 1'b0;
      fade_steps_left <= 5'h00;
      unit_cnt        <= '0;
      unit_left       <= 5'h00;
    end else if (cmd_stb && sel == rgbcd_pkg::RGBCD_F_OFF) begin
      current_step    <= 5'h00;
      fade_busy       <= 1'b0;
      fade_steps_left <= 5'h00;
    end else if (cmd_stb && sel == rgbcd_pkg::RGBCD_F_CUR) begin
      current_step    <= val;
      fade_busy       <= 1'b0;
      fade_steps_left <= 5'h00;
    end else if (cmd_stb && sel == rgbcd_pkg::RGBCD_F_RUN) begin
      fade_steps_left <= step_dist(current_step, fade_target);
      fade_busy       <= (current_step != fade_target);
      unit_cnt        <= '0;
      // a zero time field still takes one unit per step
      unit_left       <= (val == 5'h00) ? 5'h01 : val;
    end else if (fade_busy) begin
      unit_cnt <= unit_tick ? '0 : ($clog2(FADE_UNIT_CYC))'(unit_cnt + 1'b1);
      if (unit_tick) begin
        if (unit_left == 5'h01) begin
          // one step per programmed time, no divider needed
          unit_left <= (fade_step_time_run == 5'h00) ? 5'h01 : fade_step_time_run;
          if (current_step < fade_target) begin
            current_step <= 5'(current_step + 5'h01);
          end else begin
            current_step <= 5'(current_step - 5'h01);
          end
          fade_steps_left <= 5'(fade_steps_left - 5'h01);
          fade_busy       <= (fade_steps_left != 5'h01);
        end else begin
          unit_left <= 5'(unit_left - 5'h01);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      led_output_current <= 16'h0000;
    end else begin
      led_output_current <= step_current(current_step);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // duty modulators, 31 slots per period

  logic [$clog2(PWM_SLOT_CYC)-1:0] slot_cnt;
  logic [4:0]                      pwm_pos;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      slot_cnt <= '0;
      pwm_pos  <= 5'h00;
    end else if (slot_cnt == ($clog2(PWM_SLOT_CYC))'(PWM_SLOT_CYC - 1)) begin
      slot_cnt <= '0;
      pwm_pos  <= (pwm_pos == `RGBCD_PWM_LAST) ? 5'h00 : 5'(pwm_pos + 5'h01);
    end else begin
      slot_cnt <= ($clog2(PWM_SLOT_CYC))'(slot_cnt + 1'b1);
    end
  end

  // duty 0 never beats pwm_pos, 0x1F always does
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      red_modulator   <= 1'b0;
      green_modulator <= 1'b0;
      blue_modulator  <= 1'b0;
    end else begin
      red_modulator   <= pwm_pos < red_duty_level;
      green_modulator <= pwm_pos < green_duty_level;
      blue_modulator  <= pwm_pos < blue_duty_level;
    end
  end

endmodule

/* File: logic/rgbcd_host.sv */
`include "rgbcd_consts.svh"
module rgbcd_host #(
  parameter int QTR_CYC = `RGBCD_QTR_CYC
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // link
  rgbcd_if.host           link
);

  ////////////////////////////////////////////////////////////////////////////
  // quarter-bit enable and sda sampling

  logic [$clog2(QTR_CYC)-1:0] qcnt;
  logic                       qtick;
  logic [2:0]                 sda_sync;
  logic                       sda_f;

  assign qtick = (qcnt == ($clog2(QTR_CYC))'(QTR_CYC - 1));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      qcnt <= '0;
    end else begin
      qcnt <= qtick ? '0 : ($clog2(QTR_CYC))'(qcnt + 1'b1);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sda_sync <= 3'h7;
      sda_f    <= 1'b1;
    end else begin
      sda_sync <= {sda_sync[1:0], link.sda};
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame engine: start, 18 bit slots, stop

  rgbcd_pkg::rgbcd_hstate_t st;
  logic [1:0]  phase;
  logic [4:0]  slot;
  logic [17:0] frame;
  logic [7:0]  cmd_byte;
  logic        nack;
  logic        scl_hi;
  logic        sda_hi;
  logic        go;

  assign go = wr && addr == `RGBCD_REG_CMD && st == rgbcd_pkg::RGBCD_H_IDLE;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st       <= rgbcd_pkg::RGBCD_H_IDLE;
      phase    <= 2'h0;
      slot     <= 5'h00;
      frame    <= 18'h3FFFF;
      cmd_byte <= 8'h00;
      nack     <= 1'b0;
      scl_hi   <= 1'b1;
      sda_hi   <= 1'b1;
    end else if (go) begin
      // address, write bit zero, then command; ack slots released
      st       <= rgbcd_pkg::RGBCD_H_START;
      frame    <= {`RGBCD_ADDR_BYTE, 1'b1, wdata, 1'b1};
      cmd_byte <= wdata;
      nack     <= 1'b0;
      phase    <= 2'h0;
      slot     <= 5'h00;
    end else if (qtick) begin
      phase <= 2'(phase + 2'h1);
      case (st)
        rgbcd_pkg::RGBCD_H_START: begin
          if (phase == 2'h0) begin
            sda_hi <= 1'b0;
          end else if (phase == 2'h1) begin
            scl_hi <= 1'b0;
            phase  <= 2'h0;
            st     <= rgbcd_pkg::RGBCD_H_BIT;
          end
        end
        rgbcd_pkg::RGBCD_H_BIT: begin
          case (phase)
            2'h0: sda_hi <= frame[17];
            2'h1: scl_hi <= 1'b1;
            2'h2: begin
              if ((slot == 5'h08 || slot == 5'h11) && sda_f) begin
                nack <= 1'b1;
              end
            end
            default: begin
              scl_hi <= 1'b0;
              frame  <= {frame[16:0], 1'b1};
              slot   <= 5'(slot + 5'h01);
              if (slot == 5'h11 || (slot == 5'h08 && nack)) begin
                st <= rgbcd_pkg::RGBCD_H_STOP;
              end
            end
          endcase
        end
        rgbcd_pkg::RGBCD_H_STOP: begin
          case (phase)
            2'h0: sda_hi <= 1'b0;
            2'h1: scl_hi <= 1'b1;
            2'h2: sda_hi <= 1'b1;
            default: st <= rgbcd_pkg::RGBCD_H_IDLE;
          endcase
        end
        default: begin
          phase <= 2'h0;
        end
      endcase
    end
  end

  assign link.scl_o       = 1'b0;
  assign link.scl_oe      = ~scl_hi;
  assign link.sda_host_o  = 1'b0;
  assign link.sda_host_oe = ~sda_hi;

  ////////////////////////////////////////////////////////////////////////////
  // register read, one cycle later

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `RGBCD_REG_CMD:  rdata <= cmd_byte;
        `RGBCD_REG_STAT: begin
          rdata                  <= 8'h00;
          rdata[`RGBCD_STAT_BUSY] <= st != rgbcd_pkg::RGBCD_H_IDLE;
          rdata[`RGBCD_STAT_NACK] <= nack;
        end
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

/* File: logic/rgbcd_if.sv */
interface rgbcd_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // open-drain wires with pull-ups
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

  modport host (output scl_o, output scl_oe, output sda_host_o, output sda_host_oe,
                input scl, input sda);
  modport dev  (output sda_dev_o, output sda_dev_oe, input scl, input sda);
endinterface

/* File: logic/rgbcd_pkg.sv */
package rgbcd_pkg;

  typedef enum logic [2:0] {
    RGBCD_F_OFF   = 3'b000,
    RGBCD_F_CUR   = 3'b001,
    RGBCD_F_RED   = 3'b010,
    RGBCD_F_GREEN = 3'b011,
    RGBCD_F_BLUE  = 3'b100,
    RGBCD_F_UP    = 3'b101,
    RGBCD_F_DOWN  = 3'b110,
    RGBCD_F_RUN   = 3'b111
  } rgbcd_func_t;

  typedef enum logic [2:0] {
    RGBCD_D_IDLE  = 3'b000,
    RGBCD_D_ADDR  = 3'b001,
    RGBCD_D_ACKA  = 3'b010,
    RGBCD_D_DATA  = 3'b011,
    RGBCD_D_ACKD  = 3'b100,
    RGBCD_D_SKIP  = 3'b101
  } rgbcd_dstate_t;

  typedef enum logic [1:0] {
    RGBCD_H_IDLE  = 2'b00,
    RGBCD_H_START = 2'b01,
    RGBCD_H_BIT   = 2'b10,
    RGBCD_H_STOP  = 2'b11
  } rgbcd_hstate_t;

endpackage

/* File: sim/rgbcd_sva.sv */
`include "rgbcd_consts.svh"
module rgbcd_sva #(
  parameter int FADE_UNIT_CYC = 20
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        arst_n,
  // link wires
  input wire logic        scl,
  input wire logic        sda_dev_oe,
  // device outputs
  input wire logic [4:0]  current_step,
  input wire logic [15:0] led_output_current,
  input wire logic [4:0]  fade_steps_left,
  input wire logic        fade_busy
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] exp_cur;
  logic [5:0]  ack_age;
  logic [15:0] gap;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    if (current_step == 5'h00) exp_cur = 16'h0000;
    else if (current_step == `RGBCD_STEP_TOP) exp_cur = `RGBCD_CUR_FULL;
    else exp_cur = 16'(32'h7FFE / (32'd31 - 32'(current_step)));
  end

  // saturates so a long quiet spell never wraps back to "recent"
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n) ack_age <= 6'h3F;
    else if (sda_dev_oe) ack_age <= 6'h00;
    else if (ack_age != 6'h3F) ack_age <= ack_age + 6'h01;

  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n) gap <= 16'h0000;
    else if ($changed(current_step)) gap <= 16'h0000;
    else if (gap != 16'hFFFF) gap <= gap + 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_fading;
    fade_busy && $past(fade_busy);
  endsequence
  sequence s_moved;
    $changed(current_step);
  endsequence
  sequence s_ack_start;
    $rose(sda_dev_oe);
  endsequence

  AST_RST_CLEAR: assert property ($rose(arst_n) |->
    current_step == 5'h00 && !fade_busy && led_output_current == 16'h0000 && fade_steps_left == 5'h00)
    else $error("outputs not clear after reset");
  AST_CUR_MAP: assert property ($stable(current_step)[*3] |-> led_output_current == exp_cur)
    else $error("current code does not match step");
  AST_STEP_BY_ONE: assert property (s_fading ##0 s_moved |->
    current_step == $past(current_step) + 5'h01 || current_step == $past(current_step) - 5'h01)
    else $error("fade moved by more than one step");
  AST_FADE_PACE: assert property (s_fading ##0 s_moved |-> gap >= FADE_UNIT_CYC - 1)
    else $error("fade step came too early");
  AST_IDLE_STEP: assert property (!fade_busy && !$past(fade_busy) && $changed(current_step)
    |-> ack_age < 6'h10)
    else $error("step changed without a data acknowledge");
  AST_ACK_SCL_LOW: assert property (s_ack_start |-> !scl)
    else $error("ack driven while clock high");
  AST_ACK_REL: assert property ($fell(sda_dev_oe) |-> !scl)
    else $error("ack released while clock high");
  AST_ACK_HELD: assert property (s_ack_start |-> sda_dev_oe throughout (##[1:64] $rose(scl)))
    else $error("ack not held into the clock high");
  AST_BUSY_STEPS: assert property ($rose(fade_busy) |-> fade_steps_left != 5'h00)
    else $error("fade started with no steps");
endmodule

/* File: sim/test_rgb_led_i2c_command_decoder.sv */
`include "rgbcd_consts.svh"
module test_rgb_led_i2c_command_decoder;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int FADE = 20;
  localparam int SLOT = 4;

  logic        mclk;
  logic        arst_n = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        bb_scl_oe = 1'b0;
  logic        bb_sda_oe = 1'b0;
  logic        prev_busy = 1'b0;
  logic [4:0]  prev_step = 5'h00;
  logic [7:0]  lf = 8'h5A;
  logic [7:0]  rdata;
  logic        red_m, grn_m, blu_m, busy_f;
  logic [15:0] cur;
  logic [4:0]  step, left, step2;
  int          fails, checked, cyc, t_rise, dur, left0, m_step, m_tgt;
  int          exp_q [$];

  rgbcd_if link_if ();
  rgbcd_if bad_if ();

  rgbcd_host #(.QTR_CYC(8)) rgbcd_host_inst (.mclk(mclk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link_if.host));
  rgbcd_dev #(.FADE_UNIT_CYC(FADE), .PWM_SLOT_CYC(SLOT)) rgbcd_dev_inst (.mclk(mclk),
    .arst_n(arst_n), .link(link_if.dev), .red_modulator(red_m), .green_modulator(grn_m),
    .blue_modulator(blu_m), .led_output_current(cur), .current_step(step),
    .fade_steps_left(left), .fade_busy(busy_f));
  // second device faces a bench master that breaks the framing on purpose
  rgbcd_dev #(.FADE_UNIT_CYC(FADE), .PWM_SLOT_CYC(SLOT)) bad_rgbcd_dev_inst (.mclk(mclk),
    .arst_n(arst_n), .link(bad_if.dev), .red_modulator(), .green_modulator(),
    .blue_modulator(), .led_output_current(), .current_step(step2),
    .fade_steps_left(), .fade_busy());
  assign bad_if.scl_o = 1'b0;
  assign bad_if.sda_host_o = 1'b0;
  assign bad_if.scl_oe = bb_scl_oe;
  assign bad_if.sda_host_oe = bb_sda_oe;

  rgbcd_sva #(.FADE_UNIT_CYC(FADE)) rgbcd_sva_inst (.mclk(mclk), .arst_n(arst_n),
    .scl(link_if.scl), .sda_dev_oe(link_if.sda_dev_oe), .current_step(step),
    .led_output_current(cur), .fade_steps_left(left), .fade_busy(busy_f));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function automatic int cur_of(input int n);
    if (n == 0) return 0;
    if (n == 31) n = 30;
    return 32'h7FFE / (31 - n);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: saw %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // every step change is matched against the model's queue
  always @(posedge mclk) begin
    prev_step <= step;
    prev_busy <= busy_f;
    cyc <= cyc + 1;
    if (busy_f && !prev_busy) begin
      t_rise <= cyc;
      left0 <= int'(left);
    end
    if (!busy_f && prev_busy) dur <= cyc - t_rise;
    if (arst_n === 1'b1 && step !== prev_step) begin
      if (exp_q.size() == 0) check(32'(step), 32'hFF);
      else check(32'(step), 32'(exp_q.pop_front()));
    end
  end

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic send(input logic [7:0] c, input logic dbl = 1'b0);
    logic [7:0] s;
    case (c[7:5])
      3'b000: begin
        if (m_step != 0) exp_q.push_back(0);
        m_step = 0;
      end
      3'b001: begin
        if (m_step != int'(c[4:0])) exp_q.push_back(int'(c[4:0]));
        m_step = int'(c[4:0]);
      end
      3'b101, 3'b110: m_tgt = int'(c[4:0]);
      3'b111: while (m_step != m_tgt) begin
        m_step += (m_tgt > m_step) ? 1 : -1;
        exp_q.push_back(m_step);
      end
      default: ;
    endcase
    wr_reg(`RGBCD_REG_CMD, c);
    if (dbl) wr_reg(`RGBCD_REG_CMD, ~c);
    s = 8'h01;
    for (int i = 0; i < 1000 && s !== 8'h00; i++) rd_reg(`RGBCD_REG_STAT, s);
    check(32'(s), 32'h0);
    rd_reg(`RGBCD_REG_CMD, s);
    check(32'(s), 32'(c));
  endtask

  task automatic fade(input logic [7:0] c);
    int u;
    int n;
    u = (c[4:0] == 5'h00) ? 1 : int'(c[4:0]);
    n = (m_step > m_tgt) ? m_step - m_tgt : m_tgt - m_step;
    send(c);
    for (int i = 0; i < 40000 && busy_f !== 1'b0; i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    if (n > 0) begin
      check(32'(left0), 32'(n));
      check(32'((dur + FADE / 2) / (u * FADE)), 32'(n));
    end
    check(32'(cur), 32'(cur_of(m_step)));
    check(32'(exp_q.size()), 32'h0);
  endtask

  // sda is only moved while scl is held low, except at start and stop
  task automatic bb_frame(input logic [23:0] f, output logic [2:0] ak);
    bb_sda_oe <= 1'b1;
    repeat (8) @(posedge mclk);
    bb_scl_oe <= 1'b1;
    for (int b = 0; b < 3; b++)
      for (int i = 8; i >= 0; i--) begin
        repeat (8) @(posedge mclk);
        bb_sda_oe <= (i > 0) ? ~f[8 * (2 - b) + i - 1] : 1'b0;
        repeat (8) @(posedge mclk);
        bb_scl_oe <= 1'b0;
        repeat (8) @(posedge mclk);
        if (i == 0) ak[2 - b] = ~bad_if.sda;
        repeat (8) @(posedge mclk);
        bb_scl_oe <= 1'b1;
      end
    repeat (8) @(posedge mclk);
    bb_sda_oe <= 1'b1;
    repeat (8) @(posedge mclk);
    bb_scl_oe <= 1'b0;
    repeat (8) @(posedge mclk);
    bb_sda_oe <= 1'b0;
    repeat (16) @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    report_and_stop;
  end

  initial begin
    logic [7:0] s;
    logic [4:0] dv [3];
    int         cnt [3];
    logic [2:0] ak;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    rd_reg(`RGBCD_REG_STAT, s);
    check(32'(s), 32'h0);
    rd_reg(`RGBCD_REG_CMD, s);
    check(32'(s), 32'h0);
    rd_reg(4'h9, s);
    check(32'(s), 32'h0);
    check(32'({step, cur, red_m, grn_m, blu_m}), 32'h0);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      dv[0] = (i == 0) ? 5'h1F : (i == 1) ? 5'h00 : (i == 2) ? lf[4:0] : 5'h1E;
      send({3'b001, dv[0]});
      check(32'(step), 32'(dv[0]));
      check(32'(cur), 32'(cur_of(dv[0])));
    end
    for (int k = 0; k < 2; k++) begin
      lf = lfsr(lf);
      dv[0] = k ? lf[4:0] : 5'h00;
      dv[1] = k ? 5'h00 : 5'h1F;
      dv[2] = k ? 5'h1F : lf[4:0];
      for (int ch = 0; ch < 3; ch++) send({3'(ch + 2), dv[ch]});
      cnt = '{0, 0, 0};
      repeat (31 * SLOT) begin
        @(posedge mclk);
        #1;
        cnt[0] += int'(red_m === 1'b1);
        cnt[1] += int'(grn_m === 1'b1);
        cnt[2] += int'(blu_m === 1'b1);
      end
      for (int ch = 0; ch < 3; ch++) check(32'(cnt[ch]), 32'(dv[ch]) * SLOT);
    end
    lf = lfsr(lf);
    send({3'b000, lf[4:0]});
    check(32'({step, cur}), 32'h0);
    send(8'h25);
    send(8'hAF);
    fade(8'hE3);
    send(8'hC1);
    fade(8'hE4);
    fade(8'hE2);
    send(8'h22, 1'b1);
    check(32'(step), 32'h2);
    bb_frame(24'h713F00, ak);
    check(32'(ak), 32'h0);
    bb_frame(24'h723F00, ak);
    check(32'(ak), 32'h0);
    check(32'(step2), 32'h0);
    bb_frame(24'h703F2A, ak);
    check(32'(ak), 32'h6);
    check(32'(step2), 32'h1F);
    report_and_stop;
  end
endmodule
